/* cpf_front_end.sv */
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`include "cpf_regs.svh"
module cpf_front_end (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic configuration_clock_in,
  output logic configuration_clock_out,
  output logic configuration_clock_oe,
  input wire logic [15:0] data_pins,
  input wire logic program_n_pin,
  input wire logic init_n_in,
  output logic init_n_out,
  output logic init_n_oe,
  input wire logic [1:0] mode_pins,
  input wire logic crc_err,
  input wire logic readback_crc_err,
  input wire logic config_done,
  output logic word_valid,
  output cpf_pkg::cpf_word_t word_out,
  output logic irq
);

  // Pin inputs after two flops
  logic configuration_clock_s;
  logic [15:0] data_s;
  logic prog_n_s, prog_req_s;
  logic init_s;
  logic [1:0] mode_s;

  cpf_sync2 #(.W(1)) u_sync_configuration_clock (.aclk(aclk), .aresetn(aresetn), .d(configuration_clock_in), .q(configuration_clock_s));
  cpf_sync2 #(.W(16)) u_sync_data (.aclk(aclk), .aresetn(aresetn), .d(data_pins), .q(data_s));
  cpf_sync2 #(.W(1)) u_sync_prog (.aclk(aclk), .aresetn(aresetn), .d(~program_n_pin), .q(prog_req_s));
  assign prog_n_s = ~prog_req_s; // Inverted so the flop reset does not look like a request
  cpf_sync2 #(.W(1)) u_sync_init (.aclk(aclk), .aresetn(aresetn), .d(init_n_in), .q(init_s));
  cpf_sync2 #(.W(2)) u_sync_mode (.aclk(aclk), .aresetn(aresetn), .d(mode_pins), .q(mode_s));

  // Pin bit 0 carries the byte's MSB
  function automatic logic [7:0] rev8(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[7-i] = b[i];
    end
    return r;
  endfunction

  // Loader state
  cpf_pkg::cpf_state_t state_reg, state_next;
  logic [`CPF_CNT_W-1:0] init_cnt_reg, init_cnt_next;
  logic [`CPF_CNT_W-1:0] div_cnt_reg, div_cnt_next;
  logic mclk_reg, mclk_next;
  logic configuration_clock_d_reg, configuration_clock_d_next;
  logic [1:0] mode_smp_reg, mode_smp_next;
  logic master_reg, master_next;
  logic wide_reg, wide_next;
  logic crc_latch_reg, crc_latch_next;
  logic [7:0] h0_reg, h0_next, h1_reg, h1_next, h2_reg, h2_next;
  logic word_valid_reg, word_valid_next;
  cpf_pkg::cpf_word_t word_reg, word_next;
  logic prog_d_reg, prog_d_next;

  // Register file state
  logic aw_hold_reg, aw_hold_next;
  logic w_hold_reg, w_hold_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic ctrl_rb_en_reg, ctrl_rb_en_next;
  logic [`CPF_IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [`CPF_IRQ_W-1:0] irq_mask_reg, irq_mask_next;

  logic sample_strobe;
  logic [7:0] lo_b, hi_b;
  logic hit_x8, hit_x16;
  logic [`CPF_IRQ_W-1:0] events;
  logic aw_take, w_take, ar_take, wr_fire;
  cpf_pkg::cpf_status_t status_w;

  // Data strobe: own clock edge in master modes, sampled pin edge otherwise
  always_comb begin
    lo_b = rev8(data_s[7:0]);
    hi_b = rev8(data_s[15:8]);
    sample_strobe = master_reg ? (mclk_next & ~mclk_reg) : (configuration_clock_s & ~configuration_clock_d_reg);
    // x8 needs aa,99,55,66 on the low byte; x16 needs 99 then 66
    hit_x8 = (h2_reg == `CPF_SYNC_B3) && (h1_reg == `CPF_SYNC_B2) && (h0_reg == `CPF_SYNC_B1) &&
             (lo_b == `CPF_SYNC_B0);
    hit_x16 = (h0_reg == `CPF_SYNC_B2) && (lo_b == `CPF_SYNC_B0);
  end

  // Loader next-state logic
  always_comb begin
    state_next = state_reg;
    init_cnt_next = init_cnt_reg;
    div_cnt_next = div_cnt_reg;
    mclk_next = mclk_reg;
    configuration_clock_d_next = configuration_clock_s;
    mode_smp_next = mode_smp_reg;
    master_next = master_reg;
    wide_next = wide_reg;
    crc_latch_next = crc_latch_reg;
    h0_next = h0_reg;
    h1_next = h1_reg;
    h2_next = h2_reg;
    word_valid_next = 1'b0;
    word_next = word_reg;
    prog_d_next = prog_n_s;
    events = '0;
    // Master clock divider only runs once a master mode is chosen
    if (master_reg && (state_reg == cpf_pkg::ST_HUNT || state_reg == cpf_pkg::ST_LOAD)) begin
      if (div_cnt_reg == `CPF_CNT_W'(`CPF_MCLK_HALF_CYC - 1)) begin
        div_cnt_next = '0;
        mclk_next = ~mclk_reg;
      end else begin
        div_cnt_next = div_cnt_reg + `CPF_CNT_W'(1);
      end
    end
    unique case (state_reg)
      cpf_pkg::ST_INIT: begin
        // Init pin is driven low here for the clearing time
        if (init_cnt_reg == `CPF_CNT_W'(`CPF_INIT_CYC - 1)) begin
          state_next = cpf_pkg::ST_WAIT;
        end else begin
          init_cnt_next = init_cnt_reg + `CPF_CNT_W'(1);
        end
      end
      cpf_pkg::ST_WAIT: begin
        // Released, but an outside low holds us here
        if (init_s) begin
          mode_smp_next = mode_s;
          master_next = (mode_s == `CPF_MODE_MASTER);
          events[`CPF_IRQ_INIT_REL] = 1'b1;
          state_next = cpf_pkg::ST_HUNT;
        end
      end
      cpf_pkg::ST_HUNT: begin
        // Nothing leaves the block before sync
        if (sample_strobe) begin
          h2_next = h1_reg;
          h1_next = h0_reg;
          h0_next = lo_b;
          if (hit_x8) begin
            wide_next = 1'b0;
            state_next = cpf_pkg::ST_LOAD;
            events[`CPF_IRQ_SYNC] = 1'b1;
          end else if (hit_x16) begin
            wide_next = 1'b1;
            state_next = cpf_pkg::ST_LOAD;
            events[`CPF_IRQ_SYNC] = 1'b1;
          end
        end
      end
      cpf_pkg::ST_LOAD: begin
        // One word per rising configuration clock edge
        if (sample_strobe) begin
          word_valid_next = 1'b1;
          word_next.wide = wide_reg;
          word_next.data = wide_reg ? {hi_b, lo_b} : {8'h00, lo_b};
        end
        if (config_done) begin
          state_next = cpf_pkg::ST_IDLE;
        end
      end
      cpf_pkg::ST_IDLE: begin
        state_next = cpf_pkg::ST_IDLE;
      end
      default: begin
        state_next = cpf_pkg::ST_INIT;
      end
    endcase
    // Init pin as error flag only after mode sampling; stays low once set
    if ((state_reg == cpf_pkg::ST_HUNT || state_reg == cpf_pkg::ST_LOAD) && crc_err) begin
      crc_latch_next = 1'b1;
      events[`CPF_IRQ_CRC] = 1'b1;
    end
    if (state_reg == cpf_pkg::ST_IDLE && ctrl_rb_en_reg && readback_crc_err) begin
      crc_latch_next = 1'b1;
      events[`CPF_IRQ_CRC] = 1'b1;
    end
    // Program request restarts the loader and holds in init
    if (!prog_n_s) begin
      state_next = cpf_pkg::ST_INIT;
      init_cnt_next = '0;
      div_cnt_next = '0;
      mclk_next = 1'b0;
      master_next = 1'b0;
      wide_next = 1'b0;
      crc_latch_next = 1'b0;
      h0_next = 8'h00;
      h1_next = 8'h00;
      h2_next = 8'h00;
      word_valid_next = 1'b0;
      events[`CPF_IRQ_PROG] = prog_d_reg;
    end
  end

  // Loader registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= cpf_pkg::ST_INIT;
      init_cnt_reg <= '0;
      div_cnt_reg <= '0;
      mclk_reg <= 1'b0;
      configuration_clock_d_reg <= 1'b0;
      mode_smp_reg <= 2'h0;
      master_reg <= 1'b0;
      wide_reg <= 1'b0;
      crc_latch_reg <= 1'b0;
      h0_reg <= 8'h00;
      h1_reg <= 8'h00;
      h2_reg <= 8'h00;
      word_valid_reg <= 1'b0;
      word_reg <= '0;
      prog_d_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      init_cnt_reg <= init_cnt_next;
      div_cnt_reg <= div_cnt_next;
      mclk_reg <= mclk_next;
      configuration_clock_d_reg <= configuration_clock_d_next;
      mode_smp_reg <= mode_smp_next;
      master_reg <= master_next;
      wide_reg <= wide_next;
      crc_latch_reg <= crc_latch_next;
      h0_reg <= h0_next;
      h1_reg <= h1_next;
      h2_reg <= h2_next;
      word_valid_reg <= word_valid_next;
      word_reg <= word_next;
      prog_d_reg <= prog_d_next;
    end
  end

  // Open drain: only ever pull low, the board pull-up gives the high
  assign init_n_out = 1'b0;
  assign init_n_oe = (state_reg == cpf_pkg::ST_INIT) | crc_latch_reg;
  assign configuration_clock_out = mclk_reg;
  assign configuration_clock_oe = master_reg;
  assign word_valid = word_valid_reg;
  assign word_out = word_reg;

  // Status word; mode field follows the pins live
  always_comb begin
    status_w = '0;
    status_w.mode = mode_s;
    status_w.state = state_reg;
    status_w.wide = wide_reg;
    status_w.synced = (state_reg == cpf_pkg::ST_LOAD) | (state_reg == cpf_pkg::ST_IDLE);
    status_w.crc_err = crc_latch_reg;
    status_w.init_level = init_s;
    status_w.master = master_reg;
  end

  // AXI4-Lite handshakes; address and data may arrive in either order
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;

  // Register file next values
  always_comb begin
    aw_hold_next = aw_hold_reg;
    w_hold_next = w_hold_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    ctrl_rb_en_next = ctrl_rb_en_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    if (aw_take) begin
      aw_hold_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (w_take) begin
      w_hold_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `CPF_RESP_OKAY;
      unique case (awaddr_reg)
        `CPF_ADDR_CTRL: begin
          if (wstrb_reg[0]) begin
            ctrl_rb_en_next = wdata_reg[`CPF_CTRL_RB_CRC_EN];
          end
        end
        `CPF_ADDR_IRQ_MASK: begin
          if (wstrb_reg[0]) begin
            irq_mask_next = wdata_reg[`CPF_IRQ_W-1:0];
          end
        end
        `CPF_ADDR_STATUS, `CPF_ADDR_IRQ_STATUS, `CPF_ADDR_LAST_WORD: begin
          bresp_next = `CPF_RESP_OKAY;
        end
        default: begin
          bresp_next = `CPF_RESP_DECERR;
        end
      endcase
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (ar_take) begin
      rvalid_next = 1'b1;
      rresp_next = `CPF_RESP_OKAY;
      unique case (s_axi_araddr)
        `CPF_ADDR_CTRL: rdata_next = {31'h0, ctrl_rb_en_reg};
        `CPF_ADDR_STATUS: rdata_next = status_w;
        `CPF_ADDR_IRQ_STATUS: rdata_next = {28'h0, irq_stat_reg};
        `CPF_ADDR_IRQ_MASK: rdata_next = {28'h0, irq_mask_reg};
        `CPF_ADDR_LAST_WORD: rdata_next = {15'h0, word_reg};
        default: begin
          rdata_next = 32'h0;
          rresp_next = `CPF_RESP_DECERR;
        end
      endcase
      // Read clears the sticky bits it returned
      if (s_axi_araddr == `CPF_ADDR_IRQ_STATUS) begin
        irq_stat_next = '0;
      end
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    // A new event in the clearing cycle survives
    irq_stat_next = irq_stat_next | events;
  end

  // Register file registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `CPF_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `CPF_RESP_OKAY;
      ctrl_rb_en_reg <= `CPF_CTRL_RESET;
      irq_stat_reg <= `CPF_IRQ_RESET;
      irq_mask_reg <= `CPF_IRQ_RESET;
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      ctrl_rb_en_reg <= ctrl_rb_en_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  // Level interrupt from unmasked sticky bits
  assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule

/* cpf_front_end_properties.sv */
`timescale 1ns/1ns
// Port-level checks for the parallel configuration front end
module cpf_front_end_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic program_n_pin,
  input wire logic init_n_out,
  input wire logic init_n_oe,
  input wire logic crc_err,
  input wire logic config_done,
  input wire logic word_valid,
  input wire cpf_pkg::cpf_word_t word_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic loaded_reg;
  logic loaded_next;

  // A delivered word means loading; restart or done ends it, so CRC pulses elsewhere are not judged
  always_comb begin
    loaded_next = loaded_reg;
    if (word_valid) loaded_next = 1'b1;
    if (!program_n_pin || config_done) loaded_next = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) loaded_reg <= 1'b0;
    else loaded_reg <= loaded_next;
  end

  // Error and restart behaviour of the init pin
  AST_CRC_PULL: assert property (crc_err && loaded_reg && program_n_pin |=> init_n_oe)
    else $error("init pin not pulled after CRC error");
  AST_CRC_HOLD: assert property ($rose(init_n_oe) && program_n_pin && $past(program_n_pin, 4) |=> init_n_oe [*8])
    else $error("CRC error indication released early");
  AST_OPEN_DRAIN: assert property (init_n_out == 1'b0)
    else $error("init pin driven high");
  AST_PROG_HOLD: assert property (!program_n_pin [*6] |-> init_n_oe && !word_valid)
    else $error("configuration went on under program request");
  // Data strobes
  AST_WORD_PULSE: assert property (word_valid |=> !word_valid)
    else $error("word strobe longer than one cycle");
  AST_BYTE_HIGH: assert property (word_valid && !word_out.wide |-> word_out.data[15:8] == 8'h00)
    else $error("byte mode word has upper bits set");
  // Register bus handshakes
  AST_W_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");

  COV_WORD: cover property (word_valid);
  COV_CRC: cover property (crc_err && loaded_reg);
  COV_DECERR: cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
endmodule

bind cpf_front_end cpf_front_end_properties i_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .program_n_pin(program_n_pin),
  .init_n_out(init_n_out), .init_n_oe(init_n_oe), .crc_err(crc_err), .config_done(config_done),
  .word_valid(word_valid), .word_out(word_out));

/* cpf_front_end_tb_top.sv */
`timescale 1ns/1ns
`include "cpf_regs.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, a, e); end end
module cpf_front_end_tb_top;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, program_n_pin = 1'b1, hold_low = 1'b1;
  logic crc_err = 1'b0, readback_crc_err = 1'b0, config_done = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, rd;
  logic [1:0] mode_pins = 2'h1, rr, br, s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cfg_clk, init_level;
  logic init_n_out, init_n_oe, clk_oe, word_valid, irq, clk_out, clk_out_d = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [15:0] x8_seq [6] = '{16'h0066, 16'h0012, 16'h0055, 16'h0099, 16'h00aa, 16'h0066};
  logic [31:0] s_axi_rdata;
  logic [15:0] data;
  cpf_pkg::cpf_word_t word_out, last_word;
  int checks = 0, num_errors = 0, words = 0, clk_rises = 0, rises0 = 0;

  always #4 aclk = ~aclk;

  cpf_host_model i_host (.aclk(aclk), .init_n_out(init_n_out), .init_n_oe(init_n_oe), .hold_low(hold_low),
    .cfg_clk(cfg_clk), .data(data), .init_level(init_level));

  cpf_front_end i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .configuration_clock_in(cfg_clk), .configuration_clock_out(clk_out), .configuration_clock_oe(clk_oe),
    .data_pins(data), .program_n_pin(program_n_pin), .init_n_in(init_level), .init_n_out(init_n_out),
    .init_n_oe(init_n_oe), .mode_pins(mode_pins), .crc_err(crc_err), .readback_crc_err(readback_crc_err),
    .config_done(config_done), .word_valid(word_valid), .word_out(word_out), .irq(irq));

  // Capture every word handed to the packet stage
  always @(posedge aclk) begin
    if (word_valid) begin
      words++;
      last_word = word_out;
    end
    // Count rising edges of the driven configuration clock
    if (clk_out && !clk_out_d) clk_rises++;
    clk_out_d = clk_out;
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (aw && s_axi_awready) aw = 1'b0;
      if (w && s_axi_wready) w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk); // Gap so a following call never re-raises a handshake in the same step
  endtask

  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk); // Gap so back-to-back reads do not re-raise rready in the same step
  endtask

  // Poll the state field of the status register, bounded
  task automatic wait_state(input logic [4:0] st);
    int n;
    n = 0;
    do begin
      axi_rd(`CPF_ADDR_STATUS);
      n++;
    end while (rd[6:2] !== st && n < 400);
    `CHK(rd[6:2], st)
  endtask

  // One-cycle pulse: 0 CRC error, 1 configuration done, 2 readback CRC error
  task automatic pulse(input int k);
    crc_err <= (k == 0);
    config_done <= (k == 1);
    readback_crc_err <= (k == 2);
    @(posedge aclk);
    {crc_err, config_done, readback_crc_err} <= 3'h0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic wrap_up();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog sized well above the expected run
  initial begin
    repeat (60000) @(posedge aclk);
    num_errors++;
    wrap_up();
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK(init_n_oe, 1'b1)
    axi_rd(`CPF_ADDR_CTRL);
    `CHK(rd, 32'h0)
    axi_wr(`CPF_ADDR_IRQ_MASK, 32'h2);
    axi_rd(`CPF_ADDR_IRQ_MASK);
    `CHK(rd, 32'h2)
    wait_state(cpf_pkg::ST_WAIT);
    repeat (200) @(posedge aclk);
    axi_rd(`CPF_ADDR_STATUS);
    `CHK(rd[6:0], {cpf_pkg::ST_WAIT, 2'h1})
    `CHK(init_n_oe, 1'b0)
    hold_low <= 1'b0;
    wait_state(cpf_pkg::ST_HUNT);
    `CHK(clk_oe, 1'b0)
    // Junk before the sync word is dropped, then byte-wide sync
    foreach (x8_seq[i]) i_host.send(x8_seq[i]);
    `CHK(words, 0)
    i_host.send(16'h0001);
    repeat (6) @(posedge aclk);
    `CHK(last_word, 17'h00080)
    axi_rd(`CPF_ADDR_STATUS);
    `CHK(rd[8:2], {2'b10, cpf_pkg::ST_LOAD})
    axi_rd(`CPF_ADDR_IRQ_STATUS);
    `CHK(rd[3:0], 4'h5)
    axi_rd(`CPF_ADDR_IRQ_STATUS);
    `CHK(rd[3:0], 4'h0)
    mode_pins <= 2'h2;
    hold_low <= 1'b1;
    i_host.send(16'h0003);
    repeat (6) @(posedge aclk);
    `CHK(last_word, 17'h000c0)
    axi_rd(`CPF_ADDR_STATUS);
    `CHK(rd[6:0], {cpf_pkg::ST_LOAD, 2'h2})
    hold_low <= 1'b0;
    `CHK(irq, 1'b0)
    pulse(0);
    `CHK(init_level, 1'b0)
    `CHK(irq, 1'b1)
    axi_rd(`CPF_ADDR_IRQ_STATUS);
    `CHK(rd[3:0], 4'h2)
    repeat (50) @(posedge aclk);
    `CHK({irq, init_n_oe}, 2'b01)
    program_n_pin <= 1'b0;
    repeat (300) @(posedge aclk);
    axi_rd(`CPF_ADDR_STATUS);
    `CHK({rd[9], rd[6:2]}, {1'b0, cpf_pkg::ST_INIT})
    program_n_pin <= 1'b1;
    wait_state(cpf_pkg::ST_HUNT);
    i_host.send(16'h5599);
    i_host.send(16'haa66);
    i_host.send(16'h0102);
    repeat (6) @(posedge aclk);
    `CHK(last_word, 17'h18040)
    `CHK(words, 3)
    pulse(1);
    wait_state(cpf_pkg::ST_IDLE);
    pulse(2);
    `CHK(init_n_oe, 1'b0)
    axi_wr(`CPF_ADDR_CTRL, 32'h1);
    pulse(2);
    `CHK(init_n_oe, 1'b1)
    // A write without byte 0 strobed leaves the control bit alone
    s_axi_wstrb <= 4'he;
    axi_wr(`CPF_ADDR_CTRL, 32'h0);
    axi_rd(`CPF_ADDR_CTRL);
    `CHK(rd, 32'h1)
    // Master mode: clock output enabled and toggling at the divided rate
    mode_pins <= 2'h0;
    program_n_pin <= 1'b0;
    repeat (10) @(posedge aclk);
    program_n_pin <= 1'b1;
    wait_state(cpf_pkg::ST_HUNT);
    `CHK(clk_oe, 1'b1)
    rises0 = clk_rises;
    repeat (80) @(posedge aclk);
    `CHK(clk_rises - rises0, 80 / (2 * `CPF_MCLK_HALF_CYC))
    axi_rd(8'h40);
    `CHK(rr, `CPF_RESP_DECERR)
    axi_wr(8'h40, 32'h1);
    `CHK(br, `CPF_RESP_DECERR)
    wrap_up();
  end
endmodule

/* cpf_host_model.sv */
`timescale 1ns/1ns
// Host on the parallel bus; the clock idles low between words
module cpf_host_model (
  input wire logic aclk,
  input wire logic init_n_out,
  input wire logic init_n_oe,
  input wire logic hold_low,
  output logic cfg_clk,
  output logic [15:0] data,
  output logic init_level
);
  initial begin
    cfg_clk = 1'b0;
    data = 16'h5a5a;
  end

  // Board pull-up wins unless someone pulls low
  assign init_level = !(hold_low || (init_n_oe && !init_n_out));

  // One word per 160 ns clock period
  task automatic send(input logic [15:0] w);
    data <= w;
    repeat (10) @(posedge aclk);
    cfg_clk <= 1'b1;
    repeat (5) @(posedge aclk);
    data <= ~w; // Released bus must not keep showing the word
    repeat (5) @(posedge aclk);
    cfg_clk <= 1'b0;
  endtask
endmodule

/* cpf_pkg.sv */
package cpf_pkg;

  // Loader sequence, one-hot
  typedef enum logic [4:0] {
    ST_INIT = 5'b00001,
    ST_WAIT = 5'b00010,
    ST_HUNT = 5'b00100,
    ST_LOAD = 5'b01000,
    ST_IDLE = 5'b10000
  } cpf_state_t;

  // One configuration word handed to the packet stage
  typedef struct packed {
    logic wide;
    logic [15:0] data;
  } cpf_word_t;

  // Layout of the status register
  typedef struct packed {
    logic [19:0] zero;
    logic master;
    logic init_level;
    logic crc_err;
    logic synced;
    logic wide;
    logic [4:0] state;
    logic [1:0] mode;
  } cpf_status_t;

endpackage

/* cpf_regs.svh */
`ifndef CPF_REGS_SVH
`define CPF_REGS_SVH

// Register byte addresses
`define CPF_ADDR_CTRL 8'h00
`define CPF_ADDR_STATUS 8'h04
`define CPF_ADDR_IRQ_STATUS 8'h08
`define CPF_ADDR_IRQ_MASK 8'h0c
`define CPF_ADDR_LAST_WORD 8'h10

// Control fields
`define CPF_CTRL_RB_CRC_EN 0
`define CPF_CTRL_RESET 1'h0

// Interrupt status / mask bits
`define CPF_IRQ_W 4
`define CPF_IRQ_SYNC 0
`define CPF_IRQ_CRC 1
`define CPF_IRQ_INIT_REL 2
`define CPF_IRQ_PROG 3
`define CPF_IRQ_RESET 4'h0

// Sync pattern in bitstream byte order
`define CPF_SYNC_B3 8'haa
`define CPF_SYNC_B2 8'h99
`define CPF_SYNC_B1 8'h55
`define CPF_SYNC_B0 8'h66

// Mode pin code that selects a master mode
`define CPF_MODE_MASTER 2'h0

// AXI responses
`define CPF_RESP_OKAY 2'h0
`define CPF_RESP_DECERR 2'h3

// Timing
`define CPF_CLK_MHZ 125
`define CPF_INIT_NS 1000
`define CPF_INIT_CYC (((`CPF_INIT_NS * `CPF_CLK_MHZ) + 999) / 1000)
`define CPF_MCLK_HALF_NS 32
`define CPF_MCLK_HALF_CYC (((`CPF_MCLK_HALF_NS * `CPF_CLK_MHZ) + 999) / 1000)
`define CPF_CNT_W 8

`endif

/* cpf_sync2.sv */
`timescale 1ns/1ns
// Two-stage synchroniser for pins from outside the clock domain
module cpf_sync2 #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // First stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule
